//--- src/cso_map.svh
// Constants for the CANopen service-data link: identifiers, commands, objects and register map.
`ifndef CSO_MAP_SVH
`define CSO_MAP_SVH

// ----------------------------------------------------------------------------
// Identifier function codes (upper four bits of an 11-bit identifier)
// ----------------------------------------------------------------------------
`define CSO_FC_SDO_RX   4'hC
`define CSO_FC_SDO_TX   4'hB
`define CSO_FC_TPDO1    4'h3
`define CSO_FC_RPDO1    4'h4
`define CSO_NODE_MIN    7'h01
`define CSO_FRAME_BYTES 8

// ----------------------------------------------------------------------------
// Command bytes
// ----------------------------------------------------------------------------
`define CSO_CMD_READ    8'h40
`define CSO_CMD_RD1     8'h4F
`define CSO_CMD_RD2     8'h4B
`define CSO_CMD_RD4     8'h43
`define CSO_CMD_ERR     8'h80
`define CSO_CMD_WR1     8'h2F
`define CSO_CMD_WR2     8'h2B
`define CSO_CMD_WR4     8'h23
`define CSO_CMD_WR_OK   8'h60

// ----------------------------------------------------------------------------
// Object dictionary indices and reset values
// ----------------------------------------------------------------------------
`define CSO_IDX_CONTROL 16'h6040
`define CSO_IDX_STATUS  16'h6041
`define CSO_IDX_MODE    16'h6060
`define CSO_IDX_TARGET  16'h607A
`define CSO_RST_CONTROL 16'h0000
`define CSO_RST_MODE    8'h00
`define CSO_RST_TARGET  32'h0000_0000

// ----------------------------------------------------------------------------
// Controller APB register offsets and fields
// ----------------------------------------------------------------------------
`define CSO_REG_CTRL    8'h00
`define CSO_REG_TARGET  8'h04
`define CSO_REG_WDATA   8'h08
`define CSO_REG_STATUS  8'h0C
`define CSO_REG_RDATA   8'h10
`define CSO_REG_RCMD    8'h14
`define CSO_REG_NODE    8'h18
`define CSO_REG_PDO     8'h1C
`define CSO_CTRL_GO     0
`define CSO_CTRL_EXT    3
`define CSO_ST_BUSY     0
`define CSO_ST_DONE     1
`define CSO_ST_ERR      2

`endif

//--- src/cso_pkg.sv
// Types shared by both ends of the CANopen service-data link.
package cso_pkg;

  typedef enum logic [1:0] {
    CSO_SZ1 = 2'h0,
    CSO_SZ2 = 2'h1,
    CSO_SZ4 = 2'h2
  } cso_size_t;

  typedef enum logic [1:0] {
    CSO_KIND_READ  = 2'h0,
    CSO_KIND_WRITE = 2'h1,
    CSO_KIND_PDO   = 2'h2
  } cso_kind_t;

  typedef struct packed {
    logic      hit;
    logic      rd;
    logic      wr;
    logic      mappable;
    logic      storable;
    cso_size_t size;
  } cso_attr_t;

  typedef enum logic [1:0] {
    CSO_D_IDLE = 2'b00,
    CSO_D_EXEC = 2'b01,
    CSO_D_SEND = 2'b11
  } cso_dev_state_t;

  typedef enum logic [1:0] {
    CSO_H_IDLE = 2'b00,
    CSO_H_SEND = 2'b01,
    CSO_H_WAIT = 2'b11
  } cso_host_state_t;

endpackage

//--- src/cso_link_if.sv
// Frame-level link between the controller and the drive, with a wired dominant line.
`timescale 1ns/10ps
interface cso_link_if;
  logic        h_valid;
  logic        h_ready;
  logic        h_ext;
  logic [28:0] h_id;
  logic [63:0] h_data;
  logic        d_valid;
  logic        d_ready;
  logic        d_ext;
  logic [28:0] d_id;
  logic [63:0] d_data;
  logic        h_dom_oe;
  logic        d_dom_oe;
  logic        bus_level;

  // Recessive one unless either end drives dominant.
  assign bus_level = ~(h_dom_oe | d_dom_oe);

  modport dev (
    input  h_valid, h_ext, h_id, h_data, d_ready, bus_level,
    output h_ready, d_valid, d_ext, d_id, d_data, d_dom_oe
  );
  modport host (
    input  h_ready, d_valid, d_ext, d_id, d_data, bus_level,
    output h_valid, h_ext, h_id, h_data, d_ready, h_dom_oe
  );
endinterface

//--- src/cso_device.sv
// Drive end: service-data server, object dictionary and process-data frames.
//
// Design decision made here: no APB slave port; objects are reached over the frame link only.
`timescale 1ns/10ps
`include "cso_map.svh"
module cso_device (
  input  wire logic        pclk,
  input  wire logic        presetn,
  cso_link_if.dev          link,
  input  wire logic [6:0]  station_number,
  input  wire logic [15:0] status_in,
  input  wire logic        pdo_request,
  output logic [15:0]      drive_control_word,
  output logic [7:0]       operation_mode_select,
  output logic [31:0]      target_position_value,
  output logic             store_valid,
  output logic [15:0]      store_index,
  output logic [31:0]      store_data
);

  // --------------------------------------------------------------------------
  // Object dictionary attributes
  // --------------------------------------------------------------------------
  function automatic cso_pkg::cso_attr_t lookup(input logic [15:0] idx, input logic [7:0] sub);
    cso_pkg::cso_attr_t a;
    a = '0;
    if (sub == 8'h00) begin
      unique case (idx)
        `CSO_IDX_CONTROL: a = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, cso_pkg::CSO_SZ2};
        `CSO_IDX_STATUS:  a = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, cso_pkg::CSO_SZ2};
        `CSO_IDX_MODE:    a = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, cso_pkg::CSO_SZ1};
        `CSO_IDX_TARGET:  a = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, cso_pkg::CSO_SZ4};
        default:          a = '0;
      endcase
    end
    return a;
  endfunction

  // Splits an identifier into function code and node and checks both.
  function automatic logic id_match(input logic ext, input logic [28:0] id, input logic [3:0] fc,
                                    input logic [6:0] node);
    logic upper_ok;
    upper_ok = ext ? (id[28:11] == 18'h0_0000) : 1'b1;
    return upper_ok && (id[10:7] == fc) && (id[6:0] == node);
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  cso_pkg::cso_dev_state_t state;
  cso_pkg::cso_dev_state_t next_state;
  logic [63:0]             req_data;
  logic                    req_ext;
  logic                    pdo_pend;
  logic                    node_ok;
  logic                    take;
  logic                    sdo_hit;
  logic                    rpdo_hit;
  logic                    pdo_start;
  logic                    wr_ok;
  logic [7:0]              next_cmd;
  logic [31:0]             next_val;
  cso_pkg::cso_attr_t      attr;
  logic [7:0]              req_cmd;
  logic [15:0]             req_idx;
  logic [7:0]              req_sub;
  logic [31:0]             req_val;
  logic [6:0]              station_meta;
  logic [6:0]              station_sync;

  assign node_ok   = station_sync >= `CSO_NODE_MIN;
  assign link.h_ready = (state == cso_pkg::CSO_D_IDLE);
  assign take      = link.h_valid && link.h_ready;
  assign sdo_hit   = node_ok && id_match(link.h_ext, link.h_id, `CSO_FC_SDO_RX, station_sync);
  assign rpdo_hit  = node_ok && id_match(link.h_ext, link.h_id, `CSO_FC_RPDO1, station_sync);
  // A pending request from the master goes first; a process-data frame waits for a quiet line.
  assign pdo_start = (state == cso_pkg::CSO_D_IDLE) && pdo_pend && !link.h_valid
                     && link.bus_level && node_ok;

  // Byte 0 command, bytes 1-2 index low byte first, byte 3 subindex, bytes 4-7 data.
  assign req_cmd = req_data[7:0];
  assign req_idx = req_data[23:8];
  assign req_sub = req_data[31:24];
  assign req_val = req_data[63:32];
  assign attr    = lookup(req_idx, req_sub);

  // The station strap comes from pins; it is static, so a bitwise two-stage capture is enough.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      station_meta <= 7'h00;
      station_sync <= 7'h00;
    end else begin
      station_meta <= station_number;
      station_sync <= station_meta;
    end
  end

  // --------------------------------------------------------------------------
  // Request decode and reply build
  // --------------------------------------------------------------------------
  always_comb begin
    cso_pkg::cso_size_t wsz;
    wsz      = cso_pkg::CSO_SZ1;
    wr_ok    = 1'b0;
    next_cmd = `CSO_CMD_ERR;
    next_val = 32'h0000_0000;
    unique case (req_cmd)
      `CSO_CMD_WR1: wsz = cso_pkg::CSO_SZ1;
      `CSO_CMD_WR2: wsz = cso_pkg::CSO_SZ2;
      `CSO_CMD_WR4: wsz = cso_pkg::CSO_SZ4;
      default:      wsz = cso_pkg::CSO_SZ1;
    endcase
    if (req_cmd == `CSO_CMD_READ) begin
      if (attr.hit && attr.rd) begin
        unique case (attr.size)
          cso_pkg::CSO_SZ1: next_cmd = `CSO_CMD_RD1;
          cso_pkg::CSO_SZ2: next_cmd = `CSO_CMD_RD2;
          default:          next_cmd = `CSO_CMD_RD4;
        endcase
        unique case (req_idx)
          `CSO_IDX_CONTROL: next_val = {16'h0000, drive_control_word};
          `CSO_IDX_STATUS:  next_val = {16'h0000, status_in};
          `CSO_IDX_MODE:    next_val = {24'h00_0000, operation_mode_select};
          default:          next_val = 32'h0000_0000;
        endcase
      end else begin
        next_cmd = `CSO_CMD_ERR;
      end
    end else if (req_cmd == `CSO_CMD_WR1 || req_cmd == `CSO_CMD_WR2 || req_cmd == `CSO_CMD_WR4) begin
      // Write-only and read-write take writes; read-only objects and size mismatches are refused.
      if (attr.hit && attr.wr && attr.size == wsz) begin
        wr_ok    = 1'b1;
        next_cmd = `CSO_CMD_WR_OK;
      end else begin
        next_cmd = `CSO_CMD_ERR;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      cso_pkg::CSO_D_IDLE: begin
        if (take && sdo_hit) begin
          next_state = cso_pkg::CSO_D_EXEC;
        end else if (pdo_start) begin
          next_state = cso_pkg::CSO_D_SEND;
        end
      end
      cso_pkg::CSO_D_EXEC: next_state = cso_pkg::CSO_D_SEND;
      cso_pkg::CSO_D_SEND: begin
        if (link.d_ready) begin
          next_state = cso_pkg::CSO_D_IDLE;
        end
      end
      default: next_state = cso_pkg::CSO_D_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cso_pkg::CSO_D_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_data <= 64'h0000_0000_0000_0000;
      req_ext  <= 1'b0;
    end else if (take && sdo_hit) begin
      req_data <= link.h_data;
      req_ext  <= link.h_ext;
    end
  end

  // A new request in the same cycle as a send keeps the pending flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdo_pend <= 1'b0;
    end else if (pdo_request) begin
      pdo_pend <= 1'b1;
    end else if (pdo_start) begin
      pdo_pend <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Outgoing frame
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.d_ext  <= 1'b0;
      link.d_id   <= 29'h0000_0000;
      link.d_data <= 64'h0000_0000_0000_0000;
    end else if (state == cso_pkg::CSO_D_EXEC) begin
      link.d_ext  <= req_ext;
      link.d_id   <= {18'h0_0000, `CSO_FC_SDO_TX, station_sync};
      link.d_data <= {next_val, req_sub, req_idx, next_cmd};
    end else if (pdo_start) begin
      // Fixed layout holding the status word only, no header and no reply expected.
      link.d_ext  <= 1'b0;
      link.d_id   <= {18'h0_0000, `CSO_FC_TPDO1, station_sync};
      link.d_data <= {48'h0000_0000_0000, status_in};
    end
  end

  assign link.d_valid  = (state == cso_pkg::CSO_D_SEND);
  assign link.d_dom_oe = link.d_valid;

  // --------------------------------------------------------------------------
  // Object storage
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_control_word    <= `CSO_RST_CONTROL;
      operation_mode_select <= `CSO_RST_MODE;
      target_position_value <= `CSO_RST_TARGET;
    end else if (state == cso_pkg::CSO_D_EXEC && wr_ok) begin
      unique case (req_idx)
        `CSO_IDX_CONTROL: drive_control_word    <= req_val[15:0];
        `CSO_IDX_MODE:    operation_mode_select <= req_val[7:0];
        `CSO_IDX_TARGET:  target_position_value <= req_val;
        default:          drive_control_word    <= drive_control_word;
      endcase
    end else if (take && rpdo_hit) begin
      // Received process data updates the mapped control word silently.
      drive_control_word <= link.h_data[15:0];
    end
  end

  // Storable objects are handed to the non-volatile keeper on every accepted service-data write, not on received process data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_valid <= 1'b0;
      store_index <= 16'h0000;
      store_data  <= 32'h0000_0000;
    end else begin
      store_valid <= (state == cso_pkg::CSO_D_EXEC) && wr_ok && attr.storable;
      if (state == cso_pkg::CSO_D_EXEC && wr_ok && attr.storable) begin
        store_index <= req_idx;
        store_data  <= req_val;
      end
    end
  end

endmodule // cso_device

//--- src/cso_host.sv
// Controller end: APB-programmed service-data client for one drive.
`timescale 1ns/10ps
`include "cso_map.svh"
module cso_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  cso_link_if.host         link
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  cso_pkg::cso_host_state_t state;
  cso_pkg::cso_kind_t       kind;
  logic                     ext;
  logic                     go_pend;
  logic [25:0]              target;
  logic [31:0]              wdata;
  logic [31:0]              rdata;
  logic [7:0]               rcmd;
  logic [6:0]               node;
  logic [31:0]              pdo_data;
  logic                     done;
  logic                     err;
  logic                     wr_en;
  logic                     mapped;
  logic                     reply_hit;
  logic                     start;
  logic [7:0]               cmd;

  assign pready    = 1'b1;
  assign wr_en     = psel && penable && pwrite;
  assign mapped    = (paddr[1:0] == 2'b00) && (paddr <= `CSO_REG_PDO);
  assign pslverr   = psel && penable && !mapped;
  assign start     = (state == cso_pkg::CSO_H_IDLE) && go_pend && link.bus_level;
  assign reply_hit = link.d_valid && (link.d_id[10:0] == {`CSO_FC_SDO_TX, node});
  assign link.d_ready   = 1'b1;
  assign link.h_valid   = (state == cso_pkg::CSO_H_SEND);
  assign link.h_dom_oe  = link.h_valid;

  always_comb begin
    cmd = `CSO_CMD_READ;
    if (kind == cso_pkg::CSO_KIND_WRITE) begin
      unique case (target[25:24])
        2'h0:    cmd = `CSO_CMD_WR1;
        2'h1:    cmd = `CSO_CMD_WR2;
        default: cmd = `CSO_CMD_WR4;
      endcase
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      `CSO_REG_CTRL:   prdata = {28'h000_0000, ext, kind, 1'b0};
      `CSO_REG_TARGET: prdata = {6'h00, target};
      `CSO_REG_WDATA:  prdata = wdata;
      `CSO_REG_STATUS: prdata = {29'h0000_0000, err, done, (state != cso_pkg::CSO_H_IDLE) || go_pend};
      `CSO_REG_RDATA:  prdata = rdata;
      `CSO_REG_RCMD:   prdata = {24'h00_0000, rcmd};
      `CSO_REG_NODE:   prdata = {25'h000_0000, node};
      `CSO_REG_PDO:    prdata = pdo_data;
      default:         prdata = 32'h0000_0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // Software-written settings
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind    <= cso_pkg::CSO_KIND_READ;
      ext     <= 1'b0;
      go_pend <= 1'b0;
      target  <= 26'h000_0000;
      wdata   <= 32'h0000_0000;
      node    <= `CSO_NODE_MIN;
    end else begin
      if (start) begin
        go_pend <= 1'b0;
      end
      // A command written while one is in flight is ignored.
      if (wr_en && paddr == `CSO_REG_CTRL && pwdata[`CSO_CTRL_GO] && state == cso_pkg::CSO_H_IDLE && !go_pend) begin
        go_pend <= 1'b1;
        kind    <= cso_pkg::cso_kind_t'(pwdata[2:1]);
        ext     <= pwdata[`CSO_CTRL_EXT];
      end
      if (wr_en && paddr == `CSO_REG_TARGET) begin
        target <= pwdata[25:0];
      end
      if (wr_en && paddr == `CSO_REG_WDATA) begin
        wdata <= pwdata;
      end
      if (wr_en && paddr == `CSO_REG_NODE && pwdata[6:0] != 7'h00) begin
        node <= pwdata[6:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Exchange sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= cso_pkg::CSO_H_IDLE;
      link.h_ext  <= 1'b0;
      link.h_id   <= 29'h0000_0000;
      link.h_data <= 64'h0000_0000_0000_0000;
    end else begin
      unique case (state)
        cso_pkg::CSO_H_IDLE: begin
          if (start) begin
            state      <= cso_pkg::CSO_H_SEND;
            link.h_ext <= ext;
            if (kind == cso_pkg::CSO_KIND_PDO) begin
              link.h_id   <= {18'h0_0000, `CSO_FC_RPDO1, node};
              link.h_data <= {32'h0000_0000, wdata};
            end else begin
              link.h_id   <= {18'h0_0000, `CSO_FC_SDO_RX, node};
              link.h_data <= {wdata, target[23:0], cmd};
            end
          end
        end
        cso_pkg::CSO_H_SEND: begin
          if (link.h_ready) begin
            // Process data expects no answer.
            state <= (kind == cso_pkg::CSO_KIND_PDO) ? cso_pkg::CSO_H_IDLE : cso_pkg::CSO_H_WAIT;
          end
        end
        cso_pkg::CSO_H_WAIT: begin
          if (reply_hit) begin
            state <= cso_pkg::CSO_H_IDLE;
          end
        end
        default: state <= cso_pkg::CSO_H_IDLE;
      endcase
    end
  end

  // Completion flags: the reply sets, a write of one clears, and the set wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done     <= 1'b0;
      err      <= 1'b0;
      rdata    <= 32'h0000_0000;
      rcmd     <= 8'h00;
      pdo_data <= 32'h0000_0000;
    end else begin
      if (wr_en && paddr == `CSO_REG_STATUS) begin
        if (pwdata[`CSO_ST_DONE]) begin
          done <= 1'b0;
        end
        if (pwdata[`CSO_ST_ERR]) begin
          err <= 1'b0;
        end
      end
      if (state == cso_pkg::CSO_H_WAIT && reply_hit) begin
        done  <= 1'b1;
        err   <= (link.d_data[7:0] == `CSO_CMD_ERR);
        rcmd  <= link.d_data[7:0];
        rdata <= link.d_data[63:32];
      end
      if (link.d_valid && link.d_id[10:0] == {`CSO_FC_TPDO1, node}) begin
        pdo_data <= link.d_data[31:0];
      end
    end
  end

endmodule // cso_host

//--- testbench/cso_link_checker.sv
// Concurrent checks on the frame link between the controller and the drive.
`timescale 1ns/10ps
module cso_link_checker (
  input logic        pclk,
  input logic        presetn,
  input logic [6:0]  station_number,
  input logic        h_valid,
  input logic        h_ready,
  input logic        h_ext,
  input logic [28:0] h_id,
  input logic [63:0] h_data,
  input logic        d_valid,
  input logic        d_ready,
  input logic        d_ext,
  input logic [28:0] d_id,
  input logic [63:0] d_data,
  input logic        bus_level
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic take;
  logic own;
  logic other;
  assign take  = h_valid && h_ready;
  assign own   = take && h_id == 29'h0000600 + station_number;
  assign other = take && h_id[10:7] == 4'hC && h_id[6:0] != station_number;
  // --------------------------------------------------------------------------
  // Replies
  // --------------------------------------------------------------------------
  reply_slot_a: assert property (own |-> ##2 d_valid && d_id == 29'h0000580 + station_number)
    else $error("no reply frame two cycles after an own request");
  echo_a: assert property (own |-> ##2 d_data[31:8] == $past(h_data[31:8], 2))
    else $error("reply does not echo index and subindex");
  read_code_a: assert property (own && h_data[7:0] == 8'h40 |-> ##2 d_data[7:0] inside {8'h4F, 8'h4B, 8'h43, 8'h80})
    else $error("bad command in read reply");
  write_code_a: assert property (own && h_data[7:0] inside {8'h2F, 8'h2B, 8'h23} |-> ##2 d_data[7:0] inside {8'h60, 8'h80})
    else $error("bad command in write reply");
  err_zero_a: assert property (d_valid && d_id[10:7] == 4'hB && d_data[7:0] == 8'h80 |-> d_data[63:32] == 32'h0)
    else $error("error reply carries data");
  ext_reply_a: assert property (own |-> ##2 d_ext == $past(h_ext, 2))
    else $error("reply format differs from request format");
  foreign_drop_a: assert property (other |-> ##1 (!d_valid) [*2])
    else $error("reply sent to a request for another node");
  pdo_silent_a: assert property (take && h_id[10:7] == 4'h4 |-> ##1 (!d_valid) [*2])
    else $error("process data frame was answered");
  single_reply_a: assert property (d_valid && d_ready |=> !d_valid)
    else $error("reply frame repeated");
  dominant_a: assert property (d_valid |-> !bus_level)
    else $error("bus recessive while the drive transmits");
  cover property (own && h_ext);
  cover property (other);
  cover property (d_valid && d_data[7:0] == 8'h80);
  cover property (d_valid && d_id[10:7] == 4'h3);
endmodule // cso_link_checker

//--- testbench/tb_top.sv
// Testbench joining controller and drive, driven over the register bus.
`timescale 1ns/10ps
module tb_top;
  typedef struct packed {logic [3:0] c; logic [31:0] t, w; logic [7:0] r; logic [31:0] d;} cso_row_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pdo_request = 0, pready, pslverr, e;
  logic [7:0]  paddr = 8'h00, operation_mode_select;
  logic [31:0] pwdata = 32'h0, prdata, q, target_position_value;
  logic [6:0]  station_number = 7'h05;
  logic [15:0] status_in = 16'h5A3C, drive_control_word;
  int          n_fail = 0, samples_checked = 0;
  logic        store_valid;
  logic [15:0] store_index, last_idx;
  logic [31:0] store_data, last_data;
  // Size field lives in bits 25:24 of the target word; a size mismatch must be refused.
  cso_row_t rows[12] = '{'{4'h3, 32'h01006040, 32'h1234, 8'h60, 32'h0}, '{4'h1, 32'h01006040, 32'h0, 8'h4B, 32'h1234},
    '{4'h3, 32'h00006060, 32'h7, 8'h60, 32'h0}, '{4'h1, 32'h00006060, 32'h0, 8'h4F, 32'h7},
    '{4'h3, 32'h0200607A, 32'hA5A51234, 8'h60, 32'h0}, '{4'h1, 32'h0200607A, 32'h0, 8'h80, 32'h0},
    '{4'h3, 32'h01006041, 32'h1, 8'h80, 32'h0}, '{4'h1, 32'h01006041, 32'h0, 8'h4B, 32'h5A3C},
    '{4'h3, 32'h00006040, 32'h1, 8'h80, 32'h0}, '{4'h1, 32'h00001000, 32'h0, 8'h80, 32'h0},
    '{4'hB, 32'h01006040, 32'hFF, 8'h60, 32'h0}, '{4'h9, 32'h01006040, 32'h0, 8'h4B, 32'hFF}};
  cso_link_if cso_link_if_i ();
  cso_host cso_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .link(cso_link_if_i));
  cso_device cso_device_i (.pclk, .presetn, .link(cso_link_if_i), .station_number, .status_in, .pdo_request,
    .drive_control_word, .operation_mode_select, .target_position_value, .store_valid, .store_index,
    .store_data);
  cso_link_checker cso_link_checker_i (.pclk, .presetn, .station_number, .h_valid(cso_link_if_i.h_valid),
    .h_ready(cso_link_if_i.h_ready), .h_ext(cso_link_if_i.h_ext), .h_id(cso_link_if_i.h_id),
    .h_data(cso_link_if_i.h_data), .d_valid(cso_link_if_i.d_valid), .d_ready(cso_link_if_i.d_ready),
    .d_ext(cso_link_if_i.d_ext), .d_id(cso_link_if_i.d_id), .d_data(cso_link_if_i.d_data),
    .bus_level(cso_link_if_i.bus_level));
  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  initial forever #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (store_valid) begin
      last_idx  <= store_index;
      last_data <= store_data;
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    samples_checked++;
    if (s !== x) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  // Leaves the last status word in q; a request that is never answered polls out.
  task automatic sdo(input logic [31:0] c, t, w);
    apb(1'b1, 8'h08, w);
    apb(1'b1, 8'h04, t);
    apb(1'b1, 8'h00, c);
    for (int i = 0; i < 30; i++) begin
      apb(1'b0, 8'h0C, 32'h0);
      if (q[1] === 1'b1) break;
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    tally_and_finish;
  end
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 8'h18, 32'h5);
    foreach (rows[i]) begin
      sdo({28'h0, rows[i].c}, rows[i].t, rows[i].w);
      chk("done", 32'h1, {31'h0, q[1]});
      apb(1'b0, 8'h14, 32'h0);
      chk("reply command", {24'h0, rows[i].r}, q);
      apb(1'b0, 8'h10, 32'h0);
      chk("reply data", rows[i].d, q);
      apb(1'b1, 8'h0C, 32'h6);
    end
    chk("mode", 32'h7, {24'h0, operation_mode_select});
    chk("target", 32'hA5A51234, target_position_value);
    chk("store index", 32'h6040, {16'h0, last_idx});
    chk("store data", 32'hFF, last_data);
    sdo(32'h5, 32'h0, 32'h0ABC);
    chk("mapped control", 32'h0ABC, {16'h0, drive_control_word});
    pdo_request <= 1'b1;
    @(posedge pclk);
    pdo_request <= 1'b0;
    apb(1'b0, 8'h1C, 32'h0);
    chk("sent status", 32'h5A3C, {16'h0, q[15:0]});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("node kept", 32'h5, q);
    apb(1'b1, 8'h18, 32'h6);
    sdo(32'h1, 32'h01006040, 32'h0);
    chk("foreign done", 32'h0, {31'h0, q[1]});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h18, 32'h0);
    chk("node reset", 32'h1, q);
    apb(1'b1, 8'h18, 32'h5);
    chk("control reset", 32'h0, {16'h0, drive_control_word});
    sdo(32'h1, 32'h00006060, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("reply after reset", 32'h4F, q);
    tally_and_finish;
  end
endmodule // tb_top
